// ---- rtl/sps_defs.svh ----
/*
  constants of the serial to parallel shift latch: widths, depths, reset values.
  assumes it is included by its bare name from files under rtl/.
*/
// Functional notes
// - eight-stage shift register, one serial bit per shift clock, only the last stage visible
// - shift contents copy into an eight-bit holding register driving parallel outputs
// - each register has its own clock and its own overriding clear
// - both clocks act on rising edges only, never on falling edges
// - with clocks tied, holding register takes the shift contents before that edge
// - a cascade output carries the last shift stage for chaining devices
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH
`define SPS_WIDTH        8
`define SPS_FIFO_DEPTH   16
`define SPS_SHIFT_RST    8'h00
`define SPS_HOLD_RST     8'h00
`define SPS_PIN_RST      5'h00
`define SPS_PIN_LAT_MIN  2
`define SPS_PIN_LAT_MAX  3
`endif

// ---- rtl/sps_fifo.sv ----
/*
  synchronous fifo with valid and ready on both sides.
  assumes one clock mclk and synchronous active-high reset srst.
*/
`timescale 1ns/1ps
module sps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // refuse depths the pointer wrap cannot serve
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("sps_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_reg != rd_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_reg[AW-1:0]];

  // storage write
  always_ff @(posedge mclk) begin
    if (push)
      mem_reg[wr_reg[AW-1:0]] <= in_data;
  end

  // pointers
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : sps_fifo

// ---- rtl/sps_pkg.sv ----
/*
  types of the serial to parallel shift latch.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sps_pkg;
  // the five pin inputs as one carrier
  typedef struct packed {
    logic serial_in;
    logic shift_clock;
    logic holding_clock;
    logic shift_stage_clear;
    logic holding_stage_clear;
  } sps_pins_t;
endpackage : sps_pkg

// ---- rtl/sps_shift_latch.sv ----
/*
  serial-in parallel-out shift register with a holding register, pins sampled on mclk,
  each holding capture also queued into a 16-word snapshot fifo while it has room, dropped while it is full.
  assumes pin inputs are asynchronous to mclk and held for at least three mclk periods
  per level; srst is synchronous, active high.
*/
`timescale 1ns/1ps
`include "sps_defs.svh"
module sps_shift_latch #(
  parameter int WIDTH      = `SPS_WIDTH,
  parameter int FIFO_DEPTH = `SPS_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             serial_in,
  input  wire logic             shift_clock,
  input  wire logic             holding_clock,
  input  wire logic             shift_stage_clear,
  input  wire logic             holding_stage_clear,
  output logic      [WIDTH-1:0] parallel_out,
  output logic                  cascade_out,
  output logic                  snap_in_ready,
  output logic                  snap_out_valid,
  input  wire logic             snap_out_ready,
  output logic      [WIDTH-1:0] snap_out_data
);
  // refuse widths the shift path cannot serve
  initial begin
    if (WIDTH < 2 || WIDTH > 8)
      $error("sps_shift_latch: width must be 2 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling

  // accept a new level only where second and third stage agree
  function automatic sps_pkg::sps_pins_t agree_fn(
    input sps_pkg::sps_pins_t s2,
    input sps_pkg::sps_pins_t s3,
    input sps_pkg::sps_pins_t prev
  );
    agree_fn = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & prev);
  endfunction : agree_fn

  sps_pkg::sps_pins_t pin_raw;
  sps_pkg::sps_pins_t sync1_reg;
  sps_pkg::sps_pins_t sync2_reg;
  sps_pkg::sps_pins_t sync3_reg;
  sps_pkg::sps_pins_t filt_reg;
  sps_pkg::sps_pins_t filt_next;

  assign pin_raw = '{serial_in, shift_clock, holding_clock,
                     shift_stage_clear, holding_stage_clear};

  // three-stage synchroniser, first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_reg <= `SPS_PIN_RST;
      sync2_reg <= `SPS_PIN_RST;
      sync3_reg <= `SPS_PIN_RST;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign filt_next = agree_fn(sync2_reg, sync3_reg, filt_reg);

  // filtered pin levels
  always_ff @(posedge mclk) begin
    if (srst)
      filt_reg <= `SPS_PIN_RST;
    else
      filt_reg <= filt_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // edges and clears

  logic shift_rise;
  logic hold_rise;
  logic shift_clr;
  logic hold_clr;
  logic ser_bit;

  // rising edges only, falling edges do nothing
  assign shift_rise = filt_next.shift_clock & ~filt_reg.shift_clock;
  assign hold_rise  = filt_next.holding_clock & ~filt_reg.holding_clock;
  assign shift_clr  = filt_next.shift_stage_clear;
  assign hold_clr   = filt_next.holding_stage_clear;
  assign ser_bit    = filt_next.serial_in;

  ////////////////////////////////////////////////////////////////////////////////
  // shift register

  logic [WIDTH-1:0] shift_reg;

  // clear overrides the clock; each edge moves every stage one on
  always_ff @(posedge mclk) begin
    if (srst)
      shift_reg <= WIDTH'(`SPS_SHIFT_RST);
    else if (shift_clr)
      shift_reg <= '0;
    else if (shift_rise)
      shift_reg <= {shift_reg[WIDTH-2:0], ser_bit};
  end

  // last stage drives the chain output
  assign cascade_out = shift_reg[WIDTH-1];

  ////////////////////////////////////////////////////////////////////////////////
  // holding register

  logic [WIDTH-1:0] hold_reg;

  // takes the shift contents as they stood before a shared edge
  always_ff @(posedge mclk) begin
    if (srst)
      hold_reg <= WIDTH'(`SPS_HOLD_RST);
    else if (hold_clr)
      hold_reg <= '0;
    else if (hold_rise)
      hold_reg <= shift_reg;
  end

  assign parallel_out = hold_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // snapshot queue

  logic snap_push_reg;

  // one push per holding capture, one cycle after it
  always_ff @(posedge mclk) begin
    if (srst)
      snap_push_reg <= 1'b0;
    else
      snap_push_reg <= hold_rise & ~hold_clr;
  end

  sps_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_snap_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (snap_push_reg),
    .in_ready  (snap_in_ready),
    .in_data   (hold_reg),
    .out_valid (snap_out_valid),
    .out_ready (snap_out_ready),
    .out_data  (snap_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  localparam int LAT_MIN = `SPS_PIN_LAT_MIN;
  localparam int LAT_MAX = `SPS_PIN_LAT_MAX;

  property p_shift_step;
    @(posedge mclk) disable iff (srst)
      shift_rise && !shift_clr |=> shift_reg == {$past(shift_reg[WIDTH-2:0]), $past(ser_bit)};
  endproperty
  a_shift_step: assert property (p_shift_step)
    else $error("shift register did not advance by one stage");

  property p_hold_copy;
    @(posedge mclk) disable iff (srst)
      hold_rise && !hold_clr |=> parallel_out == $past(shift_reg);
  endproperty
  a_hold_copy: assert property (p_hold_copy)
    else $error("holding register did not copy shift contents");

  property p_clear_override;
    @(posedge mclk) disable iff (srst)
      shift_clr && shift_rise |=> shift_reg == '0 &&
        (hold_reg == $past(hold_reg) || $past(hold_rise) || $past(hold_clr));
  endproperty
  a_clear_override: assert property (p_clear_override)
    else $error("shift clear did not override the shift clock");

  property p_shift_clear_only;
    @(posedge mclk) disable iff (srst)
      shift_clr && !hold_clr && !hold_rise |=> $stable(hold_reg);
  endproperty
  a_shift_clear_only: assert property (p_shift_clear_only)
    else $error("shift clear disturbed the holding register");

  property p_hold_clear;
    @(posedge mclk) disable iff (srst)
      hold_clr |=> parallel_out == '0;
  endproperty
  a_hold_clear: assert property (p_hold_clear)
    else $error("holding clear did not empty the holding register");

  property p_fall_quiet;
    @(posedge mclk) disable iff (srst)
      !shift_rise && !shift_clr |=> $stable(shift_reg);
  endproperty
  a_fall_quiet: assert property (p_fall_quiet)
    else $error("shift register changed without a rising edge");

  property p_tied_lag;
    @(posedge mclk) disable iff (srst)
      shift_rise && hold_rise && !shift_clr && !hold_clr
        |=> parallel_out == $past(shift_reg) && shift_reg[0] == $past(ser_bit);
  endproperty
  a_tied_lag: assert property (p_tied_lag)
    else $error("holding register not one edge behind shift register");

  property p_cascade;
    @(posedge mclk) disable iff (srst)
      shift_rise && !shift_clr |=> cascade_out == $past(shift_reg[WIDTH-2]);
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade output is not the last stage");

  property p_pin_latency;
    @(posedge mclk) disable iff (srst)
      $rose(shift_clock) ##1 shift_clock[*3] |-> ##[LAT_MIN:LAT_MAX] filt_reg.shift_clock;
  endproperty
  a_pin_latency: assert property (p_pin_latency)
    else $error("shift clock edge not taken within three cycles");
endmodule : sps_shift_latch

// ---- tb/sps_host.sv ----
/*
  host model: drives serial data, both clocks and both clears of the latch.
  assumes the latch samples its pins on mclk and needs each level held 3 cycles.
*/
`timescale 1ns/1ps
module sps_host (
  input  wire logic         mclk,
  output sps_pkg::sps_pins_t pins
);
  // all pins low from time zero
  initial pins = '0;
  // one pin pattern set after a falling edge, held four cycles
  task automatic put(input logic [4:0] v);
    @(negedge mclk);
    pins <= v;
    repeat (4) @(negedge mclk);
  endtask : put
  // raise the masked pins for one pattern, then drop them, unmasked levels kept
  task automatic pulse(input logic [4:0] m);
    put(pins | m);
    put(pins & ~m);
  endtask : pulse
endmodule : sps_host

// ---- tb/tb.sv ----
/*
  bench of the shift latch: shifting, capture, clears, tied clocks, snapshot fifo.
  assumes sps_host drives the pins; mclk at 100 MHz, srst synchronous active high.
*/
`timescale 1ns/1ps
module tb;
  logic               mclk           = 1'b0;
  logic               srst           = 1'b1;
  logic               snap_out_ready = 1'b0;
  sps_pkg::sps_pins_t pins;
  logic         [7:0] parallel_out;
  logic         [7:0] snap_out_data;
  logic               cascade_out;
  logic               snap_in_ready;
  logic               snap_out_valid;
  logic         [7:0] sh             = 8'h00;
  logic         [7:0] q[$];
  int                 fails          = 0;
  int                 total_checks   = 0;
  localparam logic [7:0] SHIFT_PAT = 8'hA5;
  // clock
  always #5 mclk = ~mclk;
  sps_host i_host (.mclk(mclk), .pins(pins));
  sps_shift_latch i_dut (.mclk(mclk), .srst(srst), .serial_in(pins.serial_in),
    .shift_clock(pins.shift_clock), .holding_clock(pins.holding_clock),
    .shift_stage_clear(pins.shift_stage_clear),
    .holding_stage_clear(pins.holding_stage_clear), .parallel_out(parallel_out),
    .cascade_out(cascade_out), .snap_in_ready(snap_in_ready),
    .snap_out_valid(snap_out_valid), .snap_out_ready(snap_out_ready),
    .snap_out_data(snap_out_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one flag against its expected level
  task automatic chk_flag(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk_flag
  // one serial bit: rise then fall of shift_clock
  task automatic shift_bit(input logic b);
    i_host.put({b, 4'h0});
    i_host.put({b, 4'h8});
    sh = {sh[6:0], b};
    chk_flag("cascade_out", sh[7], cascade_out);
    i_host.put({b, 4'h0});
    chk_flag("cascade_out", sh[7], cascade_out);
  endtask : shift_bit
  // holding capture, value also queued as snapshot
  task automatic capture();
    i_host.pulse(5'h04);
    q.push_back(sh);
    chk("parallel_out", sh, parallel_out);
  endtask : capture
  // take one snapshot
  task automatic pop();
    chk_flag("snap_out_valid", 1'b1, snap_out_valid);
    chk("snap_out_data", q.pop_front(), snap_out_data);
    @(negedge mclk) snap_out_ready <= 1'b1;
    @(negedge mclk) snap_out_ready <= 1'b0;
  endtask : pop
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_shift();
    for (int i = 7; i >= 0; i--) shift_bit(SHIFT_PAT[i]);
    capture();
    chk("parallel_out", SHIFT_PAT, parallel_out);
    pop();
    $display("test shift done");
  endtask : t_shift
  task automatic t_tied();
    i_host.pulse(5'h1C);
    chk("parallel_out", sh, parallel_out);
    q.push_back(sh);
    sh = {sh[6:0], 1'b1};
    chk_flag("cascade_out", sh[7], cascade_out);
    pop();
    capture();
    pop();
    $display("test tied done");
  endtask : t_tied
  task automatic t_clear();
    shift_bit(1'b1);
    i_host.pulse(5'h0A);
    sh = 8'h00;
    capture();
    pop();
    shift_bit(1'b1);
    capture();
    pop();
    i_host.pulse(5'h01);
    chk("parallel_out", 8'h00, parallel_out);
    capture();
    pop();
    $display("test clear done");
  endtask : t_clear
  // mid-run reset empties both registers and the snapshot queue
  task automatic t_reset();
    capture();
    @(negedge mclk) srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    sh = 8'h00;
    q.delete();
    chk("parallel_out", 8'h00, parallel_out);
    chk_flag("cascade_out", 1'b0, cascade_out);
    chk_flag("snap_out_valid", 1'b0, snap_out_valid);
    chk_flag("snap_in_ready", 1'b1, snap_in_ready);
    shift_bit(1'b1);
    capture();
    pop();
    $display("test reset done");
  endtask : t_reset
  task automatic t_fifo();
    for (int i = 0; i < 16; i++) begin
      shift_bit(i[0]);
      capture();
    end
    chk_flag("snap_in_ready", 1'b0, snap_in_ready);
    while (q.size() > 0) begin
      repeat (2) @(negedge mclk);
      pop();
    end
    chk_flag("snap_out_valid", 1'b0, snap_out_valid);
    $display("test fifo done");
  endtask : t_fifo
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #100us;
    fails++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    chk("parallel_out", 8'h00, parallel_out);
    chk_flag("cascade_out", 1'b0, cascade_out);
    chk_flag("snap_out_valid", 1'b0, snap_out_valid);
    chk_flag("snap_in_ready", 1'b1, snap_in_ready);
    t_shift();
    t_tied();
    t_clear();
    t_reset();
    t_fifo();
    complete_run();
  end
endmodule : tb
